// File: inc/psc_pkg.sv
package psc_pkg;
    localparam int CLK_HZ = 100_000_000;
    localparam int POR_NS = 5_000;
    localparam int POR_CYC = (POR_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int RESTART_NS = 40_000;
    localparam int RESTART_CYC = (RESTART_NS * (CLK_HZ / 1_000_000)) / 1000;
    localparam int OSC_HZ = 10_000_000;
    localparam int OSC_DIV = CLK_HZ / OSC_HZ;
    localparam int INIT_CYC_A = 136;
    localparam int INIT_CYC_B = 40;
    localparam int INIT_CYC_C = 10;
    localparam int BITS_PER_BYTE = 8;
    localparam logic [1:0] INIT_SRC_OSC = 2'h0;
    localparam logic [1:0] INIT_SRC_DCLK = 2'h1;
    localparam logic [1:0] INIT_SRC_USR = 2'h2;

    typedef enum logic [2:0] {
        PSC_POR = 3'h0,
        PSC_RESET = 3'h1,
        PSC_CONFIG = 3'h2,
        PSC_INIT = 3'h3,
        PSC_USER = 3'h4,
        PSC_ERROR = 3'h5
    } psc_state_e;

    typedef struct packed {
        logic status_oe_n;
        logic done_oe_n;
        logic io_tristate;
        logic user_mode;
    } psc_status_s;
endpackage

// File: logic/psc_edge_sync.sv
// Two-stage synchroniser with rise and fall pulses taken after stage two
module psc_edge_sync (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_pin,
    output logic o_level,
    output logic o_rise,
    output logic o_fall
);
    logic s1_q;
    logic s2_q;
    logic s3_q;

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
        end else begin
            s1_q <= i_pin;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    assign o_level = s2_q;
    assign o_rise = s2_q & ~s3_q;
    assign o_fall = ~s2_q & s3_q;
endmodule

// File: logic/psc_loader.sv
// Functional notes
// - Capture byte on rise, shift on falls
// - Next byte taken on ninth rising edge
// - Power-on reset holds status low, tristates
// - Stages: reset, configuration, then initialization
// - Reset while request or status low
// - Request high releases status, accepts bytes
// - All bits received releases completion line
// - Variant A: oscillator or user clock init
// - Variant B: serial clock or user clock
// - Init lasts 136, 40 or 10 cycles
// - Error pulls status low, optional auto-restart
module psc_loader
    import psc_pkg::*;
#(
    parameter int TOTAL_BITS = 64,
    parameter int INIT_CYCLES = INIT_CYC_B,
    parameter bit OSC_VARIANT = 1'b1,
    parameter int POR_CYCLES = POR_CYC,
    parameter int RESTART_CYCLES = RESTART_CYC
) (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_dclk,
    input wire logic [7:0] i_data,
    input wire logic i_config_req_n,
    input wire logic i_status_in,
    input wire logic i_user_startup_clock,
    input wire logic i_use_user_clock,
    input wire logic i_auto_restart,
    input wire logic i_cfg_error,
    output logic o_status_o,
    output logic o_status_oe_n,
    output logic o_done_o,
    output logic o_done_oe_n,
    output logic o_io_tristate,
    output logic o_user_mode,
    output logic o_bit_valid,
    output logic o_bit
);
    if (TOTAL_BITS < 8 || TOTAL_BITS % 8 != 0 || INIT_CYCLES < 1 ||
        POR_CYCLES < 1 || RESTART_CYCLES < 1) begin : g_bad_param
        $error("psc_loader: bad parameter");
    end

    psc_state_e state_q;
    logic [31:0] timer_q;
    logic [31:0] bits_q;
    logic [7:0] shreg_q;
    logic [3:0] phase_q;
    logic [7:0] data_s1_q;
    logic [7:0] data_s2_q;
    logic [$clog2(OSC_DIV+1)-1:0] osc_q;
    logic osc_tick;
    logic dclk_rise, dclk_fall;
    logic req_lvl, req_fall;
    logic stat_lvl, usr_rise;
    logic init_tick;
    psc_status_s st;

    psc_edge_sync u_dclk (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_pin(i_dclk),
        .o_level(), .o_rise(dclk_rise), .o_fall(dclk_fall));
    psc_edge_sync u_req (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_pin(i_config_req_n),
        .o_level(req_lvl), .o_rise(), .o_fall(req_fall));
    psc_edge_sync u_stat (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_pin(i_status_in),
        .o_level(stat_lvl), .o_rise(), .o_fall());
    psc_edge_sync u_usr (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
        .i_pin(i_user_startup_clock), .o_level(), .o_rise(usr_rise), .o_fall());

    ////////////////////////////////////////////////////////////////////////
    // Data pins synchronised; hold time across the edge is the host's duty
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            data_s1_q <= 8'h00;
            data_s2_q <= 8'h00;
        end else begin
            data_s1_q <= i_data;
            data_s2_q <= data_s1_q;
        end
    end

    // Internal oscillator stand-in: one-cycle enable at the nominal rate
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            osc_q <= '0;
        end else if (osc_q == ($bits(osc_q))'(OSC_DIV - 1)) begin
            osc_q <= '0;
        end else begin
            osc_q <= osc_q + 1'b1;
        end
    end
    assign osc_tick = (osc_q == ($bits(osc_q))'(OSC_DIV - 1));

    always_comb begin
        if (i_use_user_clock) begin
            init_tick = usr_rise;
        end else if (OSC_VARIANT) begin
            init_tick = osc_tick;
        end else begin
            init_tick = dclk_rise;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Stage sequencer
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            state_q <= PSC_POR;
            timer_q <= '0;
        end else begin
            case (state_q)
                PSC_POR: begin
                    if (timer_q == 32'(POR_CYCLES - 1)) begin
                        state_q <= PSC_RESET;
                        timer_q <= '0;
                    end else begin
                        timer_q <= timer_q + 32'h0000_0001;
                    end
                end
                PSC_RESET: begin
                    // Stay until the released status line reads back high
                    if (req_lvl && stat_lvl) begin
                        state_q <= PSC_CONFIG;
                    end
                end
                PSC_CONFIG: begin
                    if (!req_lvl || !stat_lvl) begin
                        state_q <= PSC_RESET;
                    end else if (i_cfg_error) begin
                        state_q <= PSC_ERROR;
                        timer_q <= '0;
                    end else if (bits_q == 32'(TOTAL_BITS)) begin
                        state_q <= PSC_INIT;
                        timer_q <= '0;
                    end
                end
                PSC_INIT: begin
                    if (!req_lvl) begin
                        state_q <= PSC_RESET;
                    end else if (init_tick) begin
                        if (timer_q == 32'(INIT_CYCLES - 1)) begin
                            state_q <= PSC_USER;
                        end
                        timer_q <= timer_q + 32'h0000_0001;
                    end
                end
                PSC_USER: begin
                    if (req_fall) begin
                        state_q <= PSC_RESET;
                    end
                end
                PSC_ERROR: begin
                    if (req_fall) begin
                        state_q <= PSC_RESET;
                    end else if (i_auto_restart &&
                                 timer_q == 32'(RESTART_CYCLES - 1)) begin
                        state_q <= PSC_RESET;
                    end else begin
                        timer_q <= timer_q + 32'h0000_0001;
                    end
                end
                default: begin
                    state_q <= PSC_POR;
                    timer_q <= '0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Byte capture and serialisation
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            shreg_q <= 8'h00;
            phase_q <= 4'h0;
            bits_q <= '0;
            o_bit_valid <= 1'b0;
            o_bit <= 1'b0;
        end else begin
            o_bit_valid <= 1'b0;
            if (state_q != PSC_CONFIG) begin
                phase_q <= 4'h0;
                bits_q <= '0;
            end else if (dclk_rise && phase_q == 4'h0) begin
                shreg_q <= data_s2_q;
                phase_q <= 4'h8;
            end else if (dclk_fall && phase_q != 4'h0) begin
                o_bit <= shreg_q[0];
                o_bit_valid <= 1'b1;
                shreg_q <= {1'b0, shreg_q[7:1]};
                phase_q <= phase_q - 4'h1;
                bits_q <= bits_q + 32'h0000_0001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin drivers
    always_comb begin
        st.status_oe_n = !(state_q == PSC_POR || state_q == PSC_ERROR ||
                           (state_q == PSC_RESET && !req_lvl));
        st.done_oe_n = (state_q == PSC_INIT || state_q == PSC_USER);
        st.io_tristate = (state_q != PSC_USER);
        st.user_mode = (state_q == PSC_USER);
    end

    assign o_status_o = 1'b0;
    assign o_done_o = 1'b0;
    assign o_status_oe_n = st.status_oe_n;
    assign o_done_oe_n = st.done_oe_n;
    assign o_io_tristate = st.io_tristate;
    assign o_user_mode = st.user_mode;

    ////////////////////////////////////////////////////////////////////////
    // Assertions
    property p_por_hold;
        @(posedge i_ref_clk) disable iff (i_rst)
        (state_q == PSC_POR) |-> (!o_status_oe_n && o_io_tristate);
    endproperty
    a_por_hold: assert property (p_por_hold) else $error("status not held in POR");

    property p_capture;
        @(posedge i_ref_clk) disable iff (i_rst)
        (state_q == PSC_CONFIG && req_lvl && stat_lvl && !i_cfg_error &&
         dclk_rise && phase_q == 4'h0) |=> (shreg_q == $past(data_s2_q) && phase_q == 4'h8);
    endproperty
    a_capture: assert property (p_capture) else $error("byte not captured");

    property p_no_recapture;
        @(posedge i_ref_clk) disable iff (i_rst)
        (state_q == PSC_CONFIG && dclk_rise && phase_q != 4'h0) |=> $stable(shreg_q);
    endproperty
    a_no_recapture: assert property (p_no_recapture) else $error("early recapture");

    property p_reset_low;
        @(posedge i_ref_clk) disable iff (i_rst)
        (state_q == PSC_CONFIG && !req_lvl) |=> (state_q == PSC_RESET);
    endproperty
    a_reset_low: assert property (p_reset_low) else $error("no reset on low request");

    property p_release;
        @(posedge i_ref_clk) disable iff (i_rst)
        (state_q == PSC_RESET && req_lvl) |-> o_status_oe_n;
    endproperty
    a_release: assert property (p_release) else $error("status not released");

    property p_accept;
        @(posedge i_ref_clk) disable iff (i_rst)
        (state_q == PSC_RESET && req_lvl && stat_lvl) |=> (state_q == PSC_CONFIG);
    endproperty
    a_accept: assert property (p_accept) else $error("configuration not entered");

    property p_hold_reset;
        @(posedge i_ref_clk) disable iff (i_rst)
        (state_q == PSC_RESET && !(req_lvl && stat_lvl)) |=> (state_q == PSC_RESET);
    endproperty
    a_hold_reset: assert property (p_hold_reset) else $error("reset left early");

    property p_done;
        @(posedge i_ref_clk) disable iff (i_rst)
        (state_q == PSC_CONFIG) |-> !o_done_oe_n;
    endproperty
    a_done: assert property (p_done) else $error("done released early");

    property p_done_rise;
        @(posedge i_ref_clk) disable iff (i_rst)
        (state_q == PSC_CONFIG && req_lvl && stat_lvl && !i_cfg_error &&
         bits_q == 32'(TOTAL_BITS)) |=> o_done_oe_n;
    endproperty
    a_done_rise: assert property (p_done_rise) else $error("done not released");

    property p_order;
        @(posedge i_ref_clk) disable iff (i_rst)
        (state_q == PSC_USER) |-> ($past(state_q) inside {PSC_INIT, PSC_USER});
    endproperty
    a_order: assert property (p_order) else $error("stage order broken");

    property p_error;
        @(posedge i_ref_clk) disable iff (i_rst)
        (state_q == PSC_CONFIG && req_lvl && stat_lvl && i_cfg_error) |=> !o_status_oe_n;
    endproperty
    a_error: assert property (p_error) else $error("error not flagged");

    property p_init_len;
        @(posedge i_ref_clk) disable iff (i_rst)
        (state_q == PSC_INIT && $past(state_q) == PSC_CONFIG) |-> (timer_q == 32'h0000_0000);
    endproperty
    a_init_len: assert property (p_init_len) else $error("init count not cleared");

    property p_init_end;
        @(posedge i_ref_clk) disable iff (i_rst)
        (state_q == PSC_INIT && req_lvl && init_tick && timer_q == 32'(INIT_CYCLES - 1))
        |=> (state_q == PSC_USER && !o_io_tristate);
    endproperty
    a_init_end: assert property (p_init_end) else $error("user mode not entered");

    property p_init_early;
        @(posedge i_ref_clk) disable iff (i_rst)
        (state_q == PSC_INIT && timer_q < 32'(INIT_CYCLES - 1)) |=> (state_q != PSC_USER);
    endproperty
    a_init_early: assert property (p_init_early) else $error("user mode too early");
endmodule

// File: tb/psc_host_model.sv
// Behavioural host: raises the request, then streams bytes on a stalled-between-bytes clock
module psc_host_model (
    input wire logic i_clk,
    input wire logic i_go,
    input wire logic i_status,
    input wire logic i_done,
    output logic o_dclk,
    output logic [7:0] o_data,
    output logic o_config_req_n
);
    timeunit 1ns;
    timeprecision 1ps;
    int n;
    initial begin
        o_dclk = 1'b0;
        o_data = 8'h00;
        o_config_req_n = 1'b0;
    end
    always begin
        wait (i_go === 1'b1);
        o_config_req_n = 1'b1;
        n = 0;
        while (i_go === 1'b1 && i_done !== 1'b1) begin
            wait (i_status === 1'b1 || i_go !== 1'b1);
            // Realign so that no pin moves on a sampling edge of the device
            repeat (20) @(posedge i_clk);
            #1;
            o_data = 8'h96 + 8'(n * 37);
            repeat (8) begin
                #40 o_dclk = 1'b1;
                #40 o_dclk = 1'b0;
            end
            n++;
        end
        // Released bus shows the inverse of the last byte
        o_data = ~o_data;
        wait (i_go !== 1'b1);
        o_config_req_n = 1'b0;
        #2000;
    end
endmodule

// File: tb/psc_loader_test.sv
module psc_loader_test
    import psc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_ref_clk = 1'b0;
    logic i_rst = 1'b1;
    logic go = 1'b0;
    logic err = 1'b0;
    logic auto = 1'b0;
    logic usr_sel = 1'b0;
    logic usr_clk = 1'b0;
    logic dclk, req_n, st_o, st_oe_n, dn_o, dn_oe_n, io_ts, umode, bv, bt;
    logic [7:0] data;
    logic [63:0] col;
    int cnt = 0;
    int n_errors = 0;
    int comparisons = 0;
    int cyc = 0;
    // Open-drain lines with pull-ups: low only while the device drives them
    wire status_w = st_oe_n ? 1'b1 : st_o;
    wire done_w = dn_oe_n ? 1'b1 : dn_o;
    always #5 i_ref_clk = ~i_ref_clk;
    always #50 usr_clk = ~usr_clk;

    psc_host_model host (.i_clk(i_ref_clk), .i_go(go), .i_status(status_w), .i_done(done_w),
        .o_dclk(dclk),
        .o_data(data), .o_config_req_n(req_n));
    psc_loader #(.TOTAL_BITS(64), .INIT_CYCLES(40), .OSC_VARIANT(1'b1), .POR_CYCLES(10),
        .RESTART_CYCLES(20)) dut (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_dclk(dclk),
        .i_data(data), .i_config_req_n(req_n), .i_status_in(status_w),
        .i_user_startup_clock(usr_clk), .i_use_user_clock(usr_sel), .i_auto_restart(auto),
        .i_cfg_error(err), .o_status_o(st_o), .o_status_oe_n(st_oe_n), .o_done_o(dn_o),
        .o_done_oe_n(dn_oe_n), .o_io_tristate(io_ts), .o_user_mode(umode),
        .o_bit_valid(bv), .o_bit(bt));

    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge i_ref_clk) begin
        if (bv === 1'b1) begin
            col[cnt[5:0]] <= bt;
            cnt <= cnt + 1;
        end
    end
    always @(posedge i_ref_clk) begin
        cyc++;
        if (cyc == 40000) begin
            n_errors++;
            summarize();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(string what, logic [63:0] seen, logic [63:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic step(int n);
        repeat (n) @(posedge i_ref_clk);
        #1;
    endtask
    function automatic bit cond(int w);
        case (w)
            0: return st_oe_n === 1'b1;
            1: return st_oe_n === 1'b0;
            2: return dn_oe_n === 1'b1;
            default: return umode === 1'b1;
        endcase
    endfunction
    task automatic await(int w, int lim, string what);
        int k;
        k = 0;
        while (!cond(w) && k < lim) begin
            step(1);
            k++;
        end
        check(what, cond(w), 64'h0001);
    endtask
    function automatic logic [63:0] exp_bits();
        logic [63:0] e;
        for (int n = 0; n < 8; n++) begin
            e[n*8 +: 8] = 8'h96 + 8'(n * 37);
        end
        return e;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_por();
        check("status_oe_n in por", st_oe_n, 64'h0000);
        check("io_tristate in por", io_ts, 64'h0001);
        step(30);
        check("status_oe_n request low", st_oe_n, 64'h0000);
        $display("t_por finished");
    endtask
    task automatic t_load(logic sel);
        usr_sel = sel;
        go = 1'b1;
        await(0, 300, "status released");
        cnt = 0;
        await(2, 3000, "done released");
        check("serial bits", col, exp_bits());
        check("bit count", 64'(cnt), 64'h0040);
        check("io_tristate at done", io_ts, 64'h0001);
        // Both start-up sources tick once every OSC_DIV cycles in this bench
        step(INIT_CYC_B * OSC_DIV - 20);
        check("user mode not early", umode, 64'h0000);
        await(3, 40, "user mode");
        check("io_tristate in user", io_ts, 64'h0000);
        go = 1'b0;
        step(30);
        check("status_oe_n after drop", st_oe_n, 64'h0000);
        check("done_oe_n after drop", dn_oe_n, 64'h0000);
        $display("t_load finished, user clock %0b", sel);
    endtask
    task automatic t_abort();
        go = 1'b1;
        await(0, 300, "status released");
        step(100);
        check("done_oe_n in config", dn_oe_n, 64'h0000);
        go = 1'b0;
        await(1, 200, "status pulled on request drop");
        check("io_tristate after abort", io_ts, 64'h0001);
        $display("t_abort finished");
    endtask
    task automatic t_error();
        auto = 1'b1;
        go = 1'b1;
        await(0, 300, "status released");
        step(100);
        err = 1'b1;
        await(1, 10, "status pulled on error");
        err = 1'b0;
        await(0, 40, "auto restart release");
        await(2, 3000, "done after restart");
        await(3, 800, "user mode after restart");
        go = 1'b0;
        auto = 1'b0;
        step(30);
        $display("t_error finished");
    endtask
    task automatic summarize();
        $display("comparisons %0d, n_errors %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (12) @(posedge i_ref_clk);
        #1 i_rst = 1'b0;
        t_por();
        t_load(1'b0);
        t_load(1'b1);
        t_abort();
        t_error();
        summarize();
    end
endmodule
